// [core/ubt_consts.svh]
// Purpose: offsets, field positions, reset values and codes of the baud/timer block
// Assumes: byte addresses on an AXI4-Lite bus, one 32-bit word per register
// Notes: included by bare name
`ifndef UBT_CONSTS_SVH
`define UBT_CONSTS_SVH
`define UBT_OFF_MODE_REG_ZERO_CHAN_A 8'h00
`define UBT_OFF_MODE_REG_ZERO_CHAN_B 8'h04
`define UBT_OFF_CSR 8'h08
`define UBT_OFF_ACR 8'h0c
`define UBT_OFF_ISR 8'h10
`define UBT_OFF_IMR 8'h14
`define UBT_OFF_PRE_HI 8'h18
`define UBT_OFF_PRE_LO 8'h1c
`define UBT_OFF_CMD_A 8'h20
`define UBT_OFF_CMD_B 8'h24
`define UBT_OFF_START 8'h28
`define UBT_OFF_STOP 8'h2c
`define UBT_MR0_EXT_BIT 0
`define UBT_ACR_TIMER_BIT 6
`define UBT_ISR_CT_BIT 3
`define UBT_CMD_TO_ON 4'ha
`define UBT_CMD_TO_OFF 4'hc
`define UBT_SEL_RATES 4'he
`define UBT_SEL_CT 4'he
`define UBT_SEL_EXT 4'hf
`define UBT_SRC_PIN 2'h0
`define UBT_SRC_TXA 2'h1
`define UBT_SRC_OSC 2'h2
`define UBT_SRC_OSC16 2'h3
`define UBT_RESP_OKAY 2'h0
`define UBT_RESP_SLVERR 2'h2
`define UBT_CSR_RST 16'h0000
`define UBT_PRE_RST 8'h00
`endif

// [core/ubt_pkg.sv]
// Purpose: types shared by the baud/timer block
// Assumes: nothing
// Notes: one-hot restart phases of the time-out sequence
package ubt_pkg;
  typedef enum logic [2:0] {
    UBT_PH_IDLE = 3'b001,
    UBT_PH_STOP = 3'b010,
    UBT_PH_RUN = 3'b100
  } ubt_ph_t;
  typedef logic [7:0] ubt_addr_t;
endpackage

// [core/ubt_baud_timer.sv]
// Purpose: fixed-rate divider, four clock selectors and 16-bit counter/timer
// Assumes: AXI4-Lite slave on clk_i; oscillator and clock pins are asynchronous
// Notes: divider counts oscillator edges, so every rate follows the oscillator
// Operation
// - divider offers 22 rates to selectors
// - mode zero bit 0 adds extended rates
// - only channel A rate-set field counts
// - divider clocks run at sixteen times baud
// - rates scale with oscillator frequency
// - 16-bit divider, three modes, preset divisor
// - aux control bits 6:4 pick source, mode
// - output falling edge sets counter-ready flag
// - two read addresses start and stop
// - start copies presets into counter
// - stop clears counter-ready flag
// - timer gives square wave, half period preset
// - timer flags each fall; stop only clears
// - counter counts to zero, flags, wraps
// - counter reads return the live count
// - command 0xA enables, 0xC disables time-out
// - time-out mode ignores start and stop
// - character load stops, reloads, restarts counter
// - time-out end flags; mask bit interrupts
// - character or time-out-on clears flag
// - both channels: restart on either load
// - each selector picks rate, timer or external
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "ubt_consts.svh"
`default_nettype none
module ubt_baud_timer (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ubt_pkg::ubt_addr_t axi_awaddr_i,
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  output logic [1:0] axi_bresp_o,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  input wire ubt_pkg::ubt_addr_t axi_araddr_i,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  input wire logic osc_clock_input_i,
  input wire logic [3:0] ext_clk_i,
  input wire logic ct_ext_clk_i,
  input wire logic rx_load_a_i,
  input wire logic rx_load_b_i,
  output logic [3:0] tick_o,
  output logic ct_out_o,
  output logic irq_o
);
  import ubt_pkg::*;

  // divisor of the oscillator for each rate code, 16x clock
  function automatic logic [12:0] rate_div(input logic ext, input logic [3:0] code);
    logic [12:0] d;
    d = 13'h0001;
    if (!ext) begin
      case (code)
        4'h0: d = 13'h1200;
        4'h1: d = 13'h082f;
        4'h2: d = 13'h06b1;
        4'h3: d = 13'h0480;
        4'h4: d = 13'h0300;
        4'h5: d = 13'h0180;
        4'h6: d = 13'h00c0;
        4'h7: d = 13'h00db;
        4'h8: d = 13'h0060;
        4'h9: d = 13'h0030;
        4'ha: d = 13'h0020;
        4'hb: d = 13'h0018;
        4'hc: d = 13'h0006;
        4'hd: d = 13'h000c;
        default: d = 13'h0001;
      endcase
    end else begin
      case (code)
        4'h0: d = 13'h0c00;
        4'h1: d = 13'h082f;
        4'h2: d = 13'h06b1;
        4'h3: d = 13'h0600;
        4'h4: d = 13'h0300;
        4'h5: d = 13'h0180;
        4'h6: d = 13'h00c0;
        4'h7: d = 13'h0080;
        4'h8: d = 13'h0060;
        4'h9: d = 13'h0040;
        4'ha: d = 13'h0010;
        4'hb: d = 13'h0004;
        4'hc: d = 13'h0002;
        4'hd: d = 13'h0001;
        default: d = 13'h0001;
      endcase
    end
    return d;
  endfunction

  // register file and bus state
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, bvalid_q, bvalid_d;
  logic ardy_q, ardy_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  ubt_addr_t waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [1:0] wstrb_q, wstrb_d;
  logic [7:0] wdata_hi_q, wdata_hi_d;
  logic [7:0] mode_reg_zero_chan_a_q, mode_reg_zero_chan_a_d;
  logic [7:3] mode_reg_zero_chan_b_q, mode_reg_zero_chan_b_d;
  logic [15:0] csr_q, csr_d;
  logic [6:4] acr_q, acr_d;
  logic [7:0] imr_q, imr_d;
  logic [7:0] pre_hi_q, pre_hi_d, pre_lo_q, pre_lo_d;
  logic do_wr, start_cmd, stop_cmd, to_on, to_off;
  // counter state
  logic [15:0] count_q, count_d;
  logic ct_out_q, ct_out_d, run_q, run_d, flag_q, flag_d, irq_q, irq_d;
  logic to_a_q, to_a_d, to_b_q, to_b_d;
  ubt_ph_t ph_q, ph_d;
  // divider state
  logic [5:0] sync1_q, sync2_q, sync3_q;
  logic [12:0] dcnt_q [4];
  logic [12:0] dcnt_d [4];
  logic [3:0] pre16_q, pre16_d;
  logic [3:0] tick_q, tick_d;
  logic [15:0] preset;
  logic to_act, char_load, timer_mode, osc_tick, ct_tick, ct_rise;
  logic [5:0] pin_rise;

  assign preset = {pre_hi_q, pre_lo_q};
  assign to_act = to_a_q | to_b_q;
  assign char_load = (rx_load_a_i & to_a_q) | (rx_load_b_i & to_b_q);
  assign timer_mode = acr_q[`UBT_ACR_TIMER_BIT] & ~to_act;
  assign pin_rise = sync2_q & ~sync3_q;
  assign osc_tick = pin_rise[5];
  assign ct_rise = ct_out_d & ~ct_out_q;

  always_comb begin
    awrdy_d = awrdy_q;
    wrdy_d = wrdy_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ardy_d = ardy_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wdata_hi_d = wdata_hi_q;
    wstrb_d = wstrb_q;
    mode_reg_zero_chan_a_d = mode_reg_zero_chan_a_q;
    mode_reg_zero_chan_b_d = mode_reg_zero_chan_b_q;
    csr_d = csr_q;
    acr_d = acr_q;
    imr_d = imr_q;
    pre_hi_d = pre_hi_q;
    pre_lo_d = pre_lo_q;
    start_cmd = 1'b0;
    stop_cmd = 1'b0;
    to_on = 1'b0;
    to_off = 1'b0;
    if (axi_awvalid_i && awrdy_q) begin
      awrdy_d = 1'b0;
      waddr_d = axi_awaddr_i;
    end
    if (axi_wvalid_i && wrdy_q) begin
      wrdy_d = 1'b0;
      wdata_d = axi_wdata_i[7:0];
      wdata_hi_d = axi_wdata_i[15:8];
      wstrb_d = axi_wstrb_i[1:0];
    end
    // write once address and data are both held and no answer is pending
    do_wr = !awrdy_q && !wrdy_q && !bvalid_q;
    if (do_wr) begin
      bvalid_d = 1'b1;
      bresp_d = `UBT_RESP_OKAY;
      case (waddr_q)
        `UBT_OFF_MODE_REG_ZERO_CHAN_A: if (wstrb_q[0]) mode_reg_zero_chan_a_d = wdata_q;
        `UBT_OFF_MODE_REG_ZERO_CHAN_B: if (wstrb_q[0]) mode_reg_zero_chan_b_d = wdata_q[7:3];
        `UBT_OFF_CSR: begin
          if (wstrb_q[0]) csr_d[7:0] = wdata_q;
          if (wstrb_q[1]) csr_d[15:8] = wdata_hi_q;
        end
        `UBT_OFF_ACR: if (wstrb_q[0]) acr_d = wdata_q[6:4];
        `UBT_OFF_ISR: ;
        `UBT_OFF_IMR: if (wstrb_q[0]) imr_d = wdata_q;
        `UBT_OFF_PRE_HI: if (wstrb_q[0]) pre_hi_d = wdata_q;
        `UBT_OFF_PRE_LO: if (wstrb_q[0]) pre_lo_d = wdata_q;
        `UBT_OFF_CMD_A, `UBT_OFF_CMD_B: begin
          to_on = wstrb_q[0] && wdata_q[7:4] == `UBT_CMD_TO_ON;
          to_off = wstrb_q[0] && wdata_q[7:4] == `UBT_CMD_TO_OFF;
        end
        default: bresp_d = `UBT_RESP_SLVERR;
      endcase
    end
    if (bvalid_q && axi_bready_i) begin
      bvalid_d = 1'b0;
      awrdy_d = 1'b1;
      wrdy_d = 1'b1;
    end
    if (axi_arvalid_i && ardy_q) begin
      ardy_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `UBT_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (axi_araddr_i)
        `UBT_OFF_MODE_REG_ZERO_CHAN_A: rdata_d[7:0] = mode_reg_zero_chan_a_q;
        `UBT_OFF_MODE_REG_ZERO_CHAN_B: rdata_d[7:0] = {mode_reg_zero_chan_b_q, 3'h0};
        `UBT_OFF_CSR: rdata_d[15:0] = csr_q;
        `UBT_OFF_ACR: rdata_d[6:4] = acr_q;
        `UBT_OFF_ISR: rdata_d[`UBT_ISR_CT_BIT] = flag_q;
        `UBT_OFF_IMR: rdata_d[7:0] = imr_q;
        `UBT_OFF_PRE_HI: rdata_d[7:0] = count_q[15:8];
        `UBT_OFF_PRE_LO: rdata_d[7:0] = count_q[7:0];
        `UBT_OFF_CMD_A, `UBT_OFF_CMD_B: ;
        `UBT_OFF_START: start_cmd = 1'b1;
        `UBT_OFF_STOP: stop_cmd = 1'b1;
        default: rresp_d = `UBT_RESP_SLVERR;
      endcase
    end
    if (rvalid_q && axi_rready_i) begin
      rvalid_d = 1'b0;
      ardy_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `UBT_RESP_OKAY;
      ardy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `UBT_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wdata_hi_q <= 8'h00;
      wstrb_q <= 2'h0;
      mode_reg_zero_chan_a_q <= 8'h00;
      mode_reg_zero_chan_b_q <= 5'h00;
      csr_q <= `UBT_CSR_RST;
      acr_q <= 3'h0;
      imr_q <= 8'h00;
      pre_hi_q <= `UBT_PRE_RST;
      pre_lo_q <= `UBT_PRE_RST;
    end else begin
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ardy_q <= ardy_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wdata_hi_q <= wdata_hi_d;
      wstrb_q <= wstrb_d;
      mode_reg_zero_chan_a_q <= mode_reg_zero_chan_a_d;
      mode_reg_zero_chan_b_q <= mode_reg_zero_chan_b_d;
      csr_q <= csr_d;
      acr_q <= acr_d;
      imr_q <= imr_d;
      pre_hi_q <= pre_hi_d;
      pre_lo_q <= pre_lo_d;
    end
  end

  // counter/timer clock; own process so the selectors never loop back through ct_rise
  always_comb begin
    case (acr_q[5:4])
      `UBT_SRC_PIN: ct_tick = pin_rise[4];
      `UBT_SRC_TXA: ct_tick = tick_q[1];
      `UBT_SRC_OSC: ct_tick = osc_tick;
      default: ct_tick = osc_tick && pre16_q == 4'hf;
    endcase
  end

  // divider and selectors
  always_comb begin
    pre16_d = pre16_q;
    if (osc_tick) pre16_d = pre16_q + 4'h1;
    for (int i = 0; i < 4; i++) begin
      logic [12:0] dv;
      logic [3:0] sel;
      logic dt;
      dv = rate_div(mode_reg_zero_chan_a_q[`UBT_MR0_EXT_BIT], csr_q[4*i +: 4]);
      sel = csr_q[4*i +: 4];
      dt = 1'b0;
      dcnt_d[i] = dcnt_q[i];
      // oscillator edges only, so rates scale with the oscillator
      if (osc_tick) begin
        if (dcnt_q[i] >= dv - 13'h0001) begin
          dcnt_d[i] = 13'h0000;
          dt = 1'b1;
        end else begin
          dcnt_d[i] = dcnt_q[i] + 13'h0001;
        end
      end
      if (sel < `UBT_SEL_RATES) tick_d[i] = dt;
      else if (sel == `UBT_SEL_CT) tick_d[i] = ct_rise;
      else tick_d[i] = pin_rise[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sync3_q <= 6'h00;
      pre16_q <= 4'h0;
      tick_q <= 4'h0;
      for (int i = 0; i < 4; i++) dcnt_q[i] <= 13'h0000;
    end else begin
      sync1_q <= {osc_clock_input_i, ct_ext_clk_i, ext_clk_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pre16_q <= pre16_d;
      tick_q <= tick_d;
      for (int i = 0; i < 4; i++) dcnt_q[i] <= dcnt_d[i];
    end
  end

  // counter/timer
  always_comb begin
    count_d = count_q;
    ct_out_d = ct_out_q;
    run_d = run_q;
    ph_d = ph_q;
    to_a_d = to_a_q;
    to_b_d = to_b_q;
    if (to_on || to_off) begin
      if (waddr_q == `UBT_OFF_CMD_A) to_a_d = to_on;
      else to_b_d = to_on;
    end
    if (start_cmd && !to_act) begin
      count_d = preset;
      run_d = 1'b1;
      ct_out_d = 1'b1;
      // drop a restart phase left over from time-out mode
      ph_d = UBT_PH_IDLE;
    end else if (stop_cmd && !to_act && !timer_mode) begin
      run_d = 1'b0;
    end else if (to_on) begin
      run_d = 1'b0;
      ph_d = UBT_PH_IDLE;
    end else if (to_act && char_load) begin
      ph_d = UBT_PH_STOP;
    end else if (ct_tick) begin
      case (ph_q)
        UBT_PH_STOP: begin
          run_d = 1'b0;
          count_d = preset;
          ph_d = UBT_PH_RUN;
        end
        UBT_PH_RUN: begin
          run_d = 1'b1;
          ct_out_d = 1'b1;
          ph_d = UBT_PH_IDLE;
        end
        default: begin
          if (run_q && timer_mode) begin
            if (count_q <= 16'h0001) begin
              count_d = preset;
              ct_out_d = ~ct_out_q;
            end else begin
              count_d = count_q - 16'h0001;
            end
          end else if (run_q) begin
            // wraps past zero and keeps counting, output stays low
            count_d = count_q - 16'h0001;
            if (count_q == 16'h0001) ct_out_d = 1'b0;
          end
        end
      endcase
    end
    // set wins over a clear in the same cycle
    flag_d = flag_q;
    if ((stop_cmd && !to_act) || to_on || (to_act && char_load)) flag_d = 1'b0;
    if (ct_out_q && !ct_out_d) flag_d = 1'b1;
    irq_d = flag_d & imr_q[`UBT_ISR_CT_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_q <= 16'h0000;
      ct_out_q <= 1'b1;
      run_q <= 1'b0;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      ph_q <= UBT_PH_IDLE;
      to_a_q <= 1'b0;
      to_b_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ct_out_q <= ct_out_d;
      run_q <= run_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      ph_q <= ph_d;
      to_a_q <= to_a_d;
      to_b_q <= to_b_d;
    end
  end

  assign axi_awready_o = awrdy_q;
  assign axi_wready_o = wrdy_q;
  assign axi_bvalid_o = bvalid_q;
  assign axi_bresp_o = bresp_q;
  assign axi_arready_o = ardy_q;
  assign axi_rvalid_o = rvalid_q;
  assign axi_rresp_o = rresp_q;
  assign axi_rdata_o = rdata_q;
  assign tick_o = tick_q;
  assign ct_out_o = ct_out_q;
  assign irq_o = irq_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence load_seen;
    to_act && char_load && !to_on && !start_cmd && !stop_cmd;
  endsequence
  sequence stop_tick;
    ph_q == UBT_PH_STOP && ct_tick && !to_on && !char_load;
  endsequence

  flag_on_fall_a: assert property ($fell(ct_out_q) |-> flag_q)
    else $error("output fell without ready flag");
  stop_clears_a: assert property (stop_cmd && !to_act && !(ct_out_q && !ct_out_d) |=> !flag_q)
    else $error("stop left ready flag set");
  start_loads_a: assert property (start_cmd && !to_act
      |=> count_q == preset && run_q && ph_q == UBT_PH_IDLE)
    else $error("start did not load preset");
  timer_toggle_a: assert property (ct_tick && run_q && timer_mode && ph_q == UBT_PH_IDLE
      && count_q <= 16'h0001 && !start_cmd && !stop_cmd && !to_on && !char_load
      |=> ct_out_q != $past(ct_out_q) && count_q == preset)
    else $error("timer half period wrong");
  counter_zero_a: assert property (ct_tick && run_q && !timer_mode && ph_q == UBT_PH_IDLE
      && count_q == 16'h0001 && !start_cmd && !stop_cmd && !to_on && !char_load
      |=> count_q == 16'h0000 && !ct_out_q)
    else $error("counter end wrong");
  to_on_a: assert property (to_on |=> !flag_q && !run_q && to_act)
    else $error("time-out on did not clear and stop");
  restart_a: assert property (load_seen |=> ph_q == UBT_PH_STOP)
    else $error("character load did not stop counter");
  reload_a: assert property (stop_tick |=> ph_q == UBT_PH_RUN && count_q == preset && !run_q)
    else $error("counter not reloaded after stop");
  start_ignored_a: assert property (to_act && start_cmd && !run_q && ph_q == UBT_PH_IDLE
      && !ct_tick |=> !run_q)
    else $error("start acted in time-out mode");
  irq_mask_a: assert property (flag_q && imr_q[3] |-> ##[0:1] irq_o)
    else $error("masked-in ready flag gave no interrupt");
endmodule
`default_nettype wire

// [bench/ubt_host_model.sv]
// Purpose: host side of the baud/timer block, an AXI4-Lite master
// Assumes: one write and one read at a time, tasks called just after a rising edge
// Notes: waits without limit; only the bench watchdog cuts a hang short
`timescale 1ns/1ps
`default_nettype none
module ubt_host_model (
  input wire logic clk_i,
  output var ubt_pkg::ubt_addr_t awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output var ubt_pkg::ubt_addr_t araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  import ubt_pkg::*;
  initial begin
    awaddr_o = 8'h00;
    awvalid_o = 1'b0;
    wdata_o = 32'h0000_0000;
    wvalid_o = 1'b0;
    bready_o = 1'b0;
    araddr_o = 8'h00;
    arvalid_o = 1'b0;
    rready_o = 1'b0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input ubt_addr_t a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        aw_ok = 1'b1;
        awvalid_o <= 1'b0;
      end
      if (wvalid_o && wready_i) begin
        w_ok = 1'b1;
        wvalid_o <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid_i !== 1'b1);
    r = bresp_i;
    bready_o <= 1'b0;
    // one idle edge so the next call never reassigns in the same step
    @(posedge clk_i);
  endtask
  task automatic rd(input ubt_addr_t a, output logic [31:0] d, output logic [1:0] r);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge clk_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    do @(posedge clk_i); while (rvalid_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [bench/uart_baud_and_counter_timer_tb.sv]
// Purpose: self-checking bench of the baud/timer block
// Assumes: host model on the register bus, bench drives the clock pins
// Notes: counter clock pin pulses are slow so the synchroniser sees each one
`timescale 1ns/1ps
`include "ubt_consts.svh"
`default_nettype none
module uart_baud_and_counter_timer_tb;
  import ubt_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic osc = 1'b0;
  logic rx_a = 1'b0;
  logic rx_b = 1'b0;
  logic [4:0] pins = 5'h00;
  ubt_addr_t awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] tick;
  logic ct_out, irq;
  int fails = 0;
  int total_checks = 0;
  int od = 0;
  int osc_edges = 0;
  int tk[4] = '{0, 0, 0, 0};

  always #2 clk_i = ~clk_i;

  // oscillator pin at a tenth of the bus clock, rising edges counted
  always @(posedge clk_i) begin
    od <= (od == 4) ? 0 : od + 1;
    if (od == 4) begin
      osc <= ~osc;
      if (!osc) begin
        osc_edges <= osc_edges + 1;
      end
    end
  end
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (tick[i] === 1'b1) begin
        tk[i] <= tk[i] + 1;
      end
    end
  end

  ubt_baud_timer ubt_baud_timer_i (
    .clk_i(clk_i), .reset_i(reset_i),
    .axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid), .axi_awready_o(awready),
    .axi_wdata_i(wdata), .axi_wstrb_i(4'hf), .axi_wvalid_i(wvalid), .axi_wready_o(wready),
    .axi_bresp_o(bresp), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
    .axi_araddr_i(araddr), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
    .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
    .osc_clock_input_i(osc), .ext_clk_i(pins[3:0]), .ct_ext_clk_i(pins[4]),
    .rx_load_a_i(rx_a), .rx_load_b_i(rx_b), .tick_o(tick), .ct_out_o(ct_out), .irq_o(irq)
  );
  ubt_host_model ubt_host_model_i (
    .clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic w(input ubt_addr_t a, input logic [31:0] d);
    ubt_host_model_i.wr(a, d, rsp);
    chk({30'h0, rsp}, {30'h0, `UBT_RESP_OKAY}, "write response");
  endtask
  task automatic rchk(input ubt_addr_t a, input logic [7:0] e, input string m);
    ubt_host_model_i.rd(a, rdv, rsp);
    chk({24'h0, rdv[7:0]}, {24'h0, e}, m);
    chk({30'h0, rsp}, {30'h0, `UBT_RESP_OKAY}, "read response");
  endtask
  task automatic cmd(input ubt_addr_t a);
    ubt_host_model_i.rd(a, rdv, rsp);
  endtask
  task automatic pp(input int b, input int n);
    repeat (n) begin
      pins[b] <= 1'b1;
      repeat (4) @(posedge clk_i);
      pins[b] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task automatic rxp(input logic b);
    if (b) rx_b <= 1'b1;
    else rx_a <= 1'b1;
    @(posedge clk_i);
    rx_a <= 1'b0;
    rx_b <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // oscillator edges between two clean ticks of one selector
  task automatic meas(input int b, input int e, input string m);
    int t0;
    int e0;
    t0 = tk[b];
    while (tk[b] < t0 + 2) @(posedge clk_i);
    e0 = osc_edges;
    while (tk[b] < t0 + 3) @(posedge clk_i);
    chk(32'(osc_edges - e0), 32'(e), m);
  endtask
  task automatic tend(input string m);
    $display("test %s finished", m);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test;
  end

  initial begin
    int t0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk({29'h0, ct_out, irq, bvalid}, 32'h4, "reset outputs");
    rchk(`UBT_OFF_CSR, 8'h00, "clock select reset");
    tend("reset");
    ubt_host_model_i.wr(8'h30, 32'h55, rsp);
    chk({30'h0, rsp}, {30'h0, `UBT_RESP_SLVERR}, "unmapped write");
    ubt_host_model_i.rd(8'h30, rdv, rsp);
    chk({30'h0, rsp}, {30'h0, `UBT_RESP_SLVERR}, "unmapped read");
    w(`UBT_OFF_ISR, 32'hff);
    rchk(`UBT_OFF_ISR, 8'h00, "status is read only");
    w(`UBT_OFF_MODE_REG_ZERO_CHAN_B, 32'h07);
    rchk(`UBT_OFF_MODE_REG_ZERO_CHAN_B, 8'h00, "chan b rate bits reserved");
    tend("bus");
    w(`UBT_OFF_CSR, 32'hdefc);
    meas(0, 6, "rx a rate 12 set 0");
    meas(3, 12, "tx b rate 13 set 0");
    w(`UBT_OFF_MODE_REG_ZERO_CHAN_B, 32'h01);
    meas(0, 6, "chan b bit does not switch set");
    w(`UBT_OFF_MODE_REG_ZERO_CHAN_A, 32'h01);
    meas(0, 2, "rx a rate 12 extended");
    meas(3, 1, "tx b rate 13 extended");
    t0 = tk[1];
    pp(1, 3);
    chk(32'(tk[1] - t0), 32'h3, "tx a external clock");
    tend("divider");
    w(`UBT_OFF_IMR, 32'h08);
    w(`UBT_OFF_ACR, 32'h00);
    w(`UBT_OFF_PRE_HI, 32'h01);
    w(`UBT_OFF_PRE_LO, 32'h05);
    cmd(`UBT_OFF_START);
    pp(4, 2);
    rchk(`UBT_OFF_PRE_HI, 8'h01, "live count high");
    rchk(`UBT_OFF_PRE_LO, 8'h03, "live count low");
    pp(4, 258);
    chk({31'h0, ct_out}, 32'h1, "output before zero");
    rchk(`UBT_OFF_ISR, 8'h00, "no flag before zero");
    pp(4, 1);
    chk({31'h0, ct_out}, 32'h0, "output falls at zero");
    rchk(`UBT_OFF_ISR, 8'h08, "flag at zero");
    chk({31'h0, irq}, 32'h1, "masked-in flag interrupts");
    pp(4, 1);
    rchk(`UBT_OFF_PRE_HI, 8'hff, "wrap high");
    rchk(`UBT_OFF_PRE_LO, 8'hff, "wrap low");
    cmd(`UBT_OFF_STOP);
    rchk(`UBT_OFF_ISR, 8'h00, "stop clears flag");
    chk({30'h0, ct_out, irq}, 32'h0, "no interrupt after stop");
    tend("counter");
    w(`UBT_OFF_ACR, 32'h40);
    w(`UBT_OFF_PRE_HI, 32'h00);
    w(`UBT_OFF_PRE_LO, 32'h03);
    cmd(`UBT_OFF_START);
    t0 = tk[2];
    pp(4, 2);
    chk({31'h0, ct_out}, 32'h1, "timer high half");
    pp(4, 1);
    chk({31'h0, ct_out}, 32'h0, "timer falls after preset");
    rchk(`UBT_OFF_ISR, 8'h08, "timer flag on fall");
    cmd(`UBT_OFF_STOP);
    rchk(`UBT_OFF_ISR, 8'h00, "stop clears timer flag");
    pp(4, 3);
    chk({31'h0, ct_out}, 32'h1, "stop keeps square wave");
    chk(32'(tk[2] - t0), 32'h1, "rx b ticks on timer rise");
    pp(4, 3);
    rchk(`UBT_OFF_ISR, 8'h08, "flag on next fall");
    tend("timer");
    w(`UBT_OFF_ACR, 32'h00);
    w(`UBT_OFF_PRE_LO, 32'h02);
    w(`UBT_OFF_CMD_A, 32'ha0);
    rchk(`UBT_OFF_ISR, 8'h00, "time-out on clears flag");
    cmd(`UBT_OFF_START);
    pp(4, 4);
    rchk(`UBT_OFF_ISR, 8'h00, "start ignored, held stopped");
    rxp(1'b0);
    pp(4, 2);
    rchk(`UBT_OFF_ISR, 8'h00, "restart after load");
    pp(4, 3);
    rchk(`UBT_OFF_ISR, 8'h08, "time-out sets flag");
    chk({31'h0, irq}, 32'h1, "time-out interrupts");
    cmd(`UBT_OFF_STOP);
    rchk(`UBT_OFF_ISR, 8'h08, "stop ignored in time-out");
    rxp(1'b0);
    rchk(`UBT_OFF_ISR, 8'h00, "character clears flag");
    chk({31'h0, irq}, 32'h0, "character clears interrupt");
    w(`UBT_OFF_CMD_B, 32'ha0);
    pp(4, 5);
    rxp(1'b1);
    rchk(`UBT_OFF_ISR, 8'h00, "either load restarts");
    pp(4, 4);
    rchk(`UBT_OFF_ISR, 8'h08, "time-out after b restart");
    rxp(1'b1);
    w(`UBT_OFF_CMD_A, 32'hc0);
    w(`UBT_OFF_CMD_B, 32'hc0);
    cmd(`UBT_OFF_START);
    pp(4, 2);
    rchk(`UBT_OFF_ISR, 8'h08, "start works after off");
    tend("time-out");
    finish_test;
  end
endmodule
`default_nettype wire
